// [hdl/bfbi_pkg.sv]
// Purpose: Shared constants for the boot flash bus host controller
// Assumes: 100 MHz clock; flash pins buffered by the board
// Notes: Command codes and pulse times are named once here
package bfbi_pkg;
   // Clock and bus-cycle timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_STROBE_NS = 100;   // Least strobe-low time, covers access plus sync
   localparam int T_RECOVER_NS = 30;   // Least strobe-high time between cycles
   localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_STROBE_FIRST = 5'h01;
   localparam logic [CNT_W-1:0] CNT_STROBE_LAST = CNT_W'(STROBE_CYC);
   localparam logic [CNT_W-1:0] CNT_CYC_LAST = CNT_W'(STROBE_CYC + RECOVER_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

   // Widths
   localparam int ADDR_W = 18;
   localparam int BADDR_W = 19;
   localparam int DATA_W = 16;

   // Command codes, written on the low byte only
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_IDENTIFY = 8'h90;   // Plain default, adjust per part
   localparam int STATUS_READY_BIT = 7;          // Sequencer ready flag in status byte

   // User operations
   typedef enum logic [2:0] {
      BFBI_OP_READ = 3'h0,
      BFBI_OP_PROGRAM = 3'h1,
      BFBI_OP_ERASE = 3'h2,
      BFBI_OP_IDENT_CMD = 3'h3,
      BFBI_OP_IDENT_HV = 3'h4,
      BFBI_OP_READ_ARRAY = 3'h5
   } bfbi_op_e;

   // Controller states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CMD1 = 3'h1,
      ST_CMD2 = 3'h2,
      ST_POLL = 3'h3,
      ST_RDARR = 3'h4,
      ST_READ = 3'h5,
      ST_DONE = 3'h6
   } bfbi_state_e;
endpackage

// [hdl/bfbi_sync.sv]
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Synchronous active-low reset
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module bfbi_sync #(
   parameter int W = 16
) (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // Pins change with no relation to our clock
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= i_d;
         q_ff <= meta_ff;
      end
   end

   assign o_q = q_ff;
endmodule

// [hdl/bfbi_host.sv]
// Purpose: Host controller driving a boot-block flash over its parallel pins
// Assumes: One request at a time; flash answers within the strobe time
// Notes: Program and erase end with a status poll and a read-array write
`timescale 1ns/1ps
// Functional notes
// - Byte mode: top data pin carries address
// - Commands only on low data byte
// - Program supply high until operation completes
// - Erase is setup 20h then D0h
// - Program is setup then one data cycle
// - Read-array FFh after program or erase
// - Boot block needs write-protect pin high
module bfbi_host (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic I_REQ,
   input wire logic [2:0] I_OP,
   input wire logic [bfbi_pkg::BADDR_W-1:0] I_ADDR,
   input wire logic [bfbi_pkg::DATA_W-1:0] I_WDATA,
   input wire logic I_WORD_MODE,
   input wire logic I_BOOT_UNLOCK,
   output logic O_READY,
   output logic O_DONE,
   output logic [bfbi_pkg::DATA_W-1:0] O_RDATA,
   output logic [7:0] O_STATUS,
   output logic O_CE_N,
   output logic O_OE_N,
   output logic O_WE_N,
   output logic O_RP_N,
   output logic O_WP,
   output logic O_BYTE_N,
   output logic [bfbi_pkg::ADDR_W-1:0] O_A,
   output logic [bfbi_pkg::DATA_W-1:0] O_DQ,
   output logic [bfbi_pkg::DATA_W-1:0] O_DQ_OE,
   input wire logic [bfbi_pkg::DATA_W-1:0] I_DQ,
   output logic O_VPP_HI,
   output logic O_ID_HV
);
   bfbi_pkg::bfbi_state_e state_ff, nxt_state;
   logic [bfbi_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [2:0] op_ff;
   logic [bfbi_pkg::BADDR_W-1:0] addr_ff;
   logic [bfbi_pkg::DATA_W-1:0] wdata_ff;
   logic word_ff;
   logic unlock_ff;
   logic ready_ff, done_ff, vpp_ff, rp_n_ff, ce_n_ff, oe_n_ff, we_n_ff, id_hv_ff;
   logic [bfbi_pkg::DATA_W-1:0] rdata_ff;
   logic [7:0] status_ff;
   logic [bfbi_pkg::ADDR_W-1:0] a_ff;
   logic [bfbi_pkg::DATA_W-1:0] dq_ff, dq_oe_ff;
   logic [bfbi_pkg::DATA_W-1:0] dq_sync;

   // Data pins come from another timing domain
   bfbi_sync #(.W(bfbi_pkg::DATA_W)) u_dq_sync (
      .I_CLK(I_CLK),
      .I_RESETN(I_RESETN),
      .i_d(I_DQ),
      .o_q(dq_sync)
   );

   // Bus-cycle phase decode
   wire cyc_last = (cnt_ff == bfbi_pkg::CNT_CYC_LAST);
   wire in_strobe = (cnt_ff >= bfbi_pkg::CNT_STROBE_FIRST) &&
                    (cnt_ff <= bfbi_pkg::CNT_STROBE_LAST);
   wire sample = (cnt_ff == bfbi_pkg::CNT_STROBE_LAST);
   wire busy = (state_ff != bfbi_pkg::ST_IDLE) && (state_ff != bfbi_pkg::ST_DONE);
   wire is_rd = (state_ff == bfbi_pkg::ST_POLL) || (state_ff == bfbi_pkg::ST_READ);
   wire is_wr = busy && !is_rd;
   wire is_pe = (op_ff == bfbi_pkg::BFBI_OP_PROGRAM) || (op_ff == bfbi_pkg::BFBI_OP_ERASE);
   wire accept = (state_ff == bfbi_pkg::ST_IDLE) && I_REQ;
   wire seq_ready = dq_sync[bfbi_pkg::STATUS_READY_BIT];

   // Command byte for each write cycle; only the low byte matters
   wire [7:0] cmd1_byte =
      (op_ff == bfbi_pkg::BFBI_OP_PROGRAM) ? bfbi_pkg::CMD_PROGRAM_SETUP :
      (op_ff == bfbi_pkg::BFBI_OP_ERASE) ? bfbi_pkg::CMD_ERASE_SETUP :
      (op_ff == bfbi_pkg::BFBI_OP_IDENT_CMD) ? bfbi_pkg::CMD_IDENTIFY :
      bfbi_pkg::CMD_READ_ARRAY;
   wire data_cycle = (state_ff == bfbi_pkg::ST_CMD2) && (op_ff == bfbi_pkg::BFBI_OP_PROGRAM);
   wire [7:0] low_byte =
      data_cycle ? wdata_ff[7:0] :
      (state_ff == bfbi_pkg::ST_CMD2) ? bfbi_pkg::CMD_ERASE_CONFIRM :
      (state_ff == bfbi_pkg::ST_RDARR) ? bfbi_pkg::CMD_READ_ARRAY : cmd1_byte;

   // Address: word index in word mode, byte index over 19 bits otherwise
   wire [bfbi_pkg::ADDR_W-1:0] pin_addr = word_ff ? addr_ff[bfbi_pkg::ADDR_W-1:0] :
                                          addr_ff[bfbi_pkg::BADDR_W-1:1];

   // Drive plan: upper bits only on word data cycles, top pin as address in byte mode
   wire [6:0] mid_oe = (word_ff && data_cycle) ? 7'h7f : 7'h00;
   wire top_oe = busy && (word_ff ? data_cycle : 1'b1);
   wire top_val = word_ff ? wdata_ff[15] : addr_ff[0];
   wire [7:0] low_oe = is_wr ? 8'hff : 8'h00; // Released on reads so the flash can drive

   // Read word as seen by the user
   wire [bfbi_pkg::DATA_W-1:0] rd_word = word_ff ? dq_sync : {8'h00, dq_sync[7:0]};

   // Sequencing of reads and of the one- and two-cycle command operations
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      if (busy) begin
         nxt_cnt = cyc_last ? bfbi_pkg::CNT_ZERO : cnt_ff + 5'h01;
      end
      case (state_ff)
         bfbi_pkg::ST_IDLE: begin
            if (I_REQ) begin
               nxt_cnt = bfbi_pkg::CNT_ZERO;
               if ((I_OP == bfbi_pkg::BFBI_OP_READ) || (I_OP == bfbi_pkg::BFBI_OP_IDENT_HV)) begin
                  nxt_state = bfbi_pkg::ST_READ;
               end else begin
                  nxt_state = bfbi_pkg::ST_CMD1;
               end
            end
         end
         bfbi_pkg::ST_CMD1: begin
            if (cyc_last) begin
               nxt_state = is_pe ? bfbi_pkg::ST_CMD2 : bfbi_pkg::ST_DONE;
            end
         end
         bfbi_pkg::ST_CMD2: begin
            if (cyc_last) begin
               nxt_state = bfbi_pkg::ST_POLL;
            end
         end
         bfbi_pkg::ST_POLL: begin
            // Status shows until a read-array write restores the array
            if (cyc_last && status_ff[bfbi_pkg::STATUS_READY_BIT]) begin
               nxt_state = bfbi_pkg::ST_RDARR;
            end
         end
         bfbi_pkg::ST_RDARR: begin
            if (cyc_last) begin
               nxt_state = bfbi_pkg::ST_DONE;
            end
         end
         bfbi_pkg::ST_READ: begin
            if (cyc_last) begin
               nxt_state = bfbi_pkg::ST_DONE;
            end
         end
         bfbi_pkg::ST_DONE: begin
            nxt_state = bfbi_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = bfbi_pkg::ST_IDLE;
            nxt_cnt = bfbi_pkg::CNT_ZERO;
         end
      endcase
   end

   // State, counter and latched request
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         state_ff <= bfbi_pkg::ST_IDLE;
         cnt_ff <= bfbi_pkg::CNT_ZERO;
         op_ff <= 3'h0;
         addr_ff <= '0;
         wdata_ff <= '0;
         word_ff <= 1'b0;
         unlock_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         if (accept) begin
            op_ff <= I_OP;
            addr_ff <= I_ADDR;
            wdata_ff <= I_WDATA;
            word_ff <= I_WORD_MODE;
            unlock_ff <= I_BOOT_UNLOCK;
         end
      end
   end

   // Control strobes; CE frames each cycle, OE and WE are exclusive
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         rp_n_ff <= 1'b0;
         ce_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         we_n_ff <= 1'b1;
      end else begin
         rp_n_ff <= 1'b1;
         ce_n_ff <= !(busy && !cyc_last);
         oe_n_ff <= !(is_rd && in_strobe);
         we_n_ff <= !(is_wr && in_strobe);
      end
   end

   // Address, data and high-voltage requests
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         a_ff <= '0;
         dq_ff <= '0;
         dq_oe_ff <= '0;
         vpp_ff <= 1'b0;
         id_hv_ff <= 1'b0;
      end else begin
         a_ff <= pin_addr;
         dq_ff <= {top_val, wdata_ff[14:8], low_byte};
         dq_oe_ff <= {top_oe, mid_oe, low_oe};
         // Raised from setup so it is stable by the confirm or data cycle
         if ((state_ff == bfbi_pkg::ST_CMD1) && is_pe) begin
            vpp_ff <= 1'b1;
         end else if (state_ff == bfbi_pkg::ST_RDARR) begin
            vpp_ff <= 1'b0;
         end
         id_hv_ff <= (state_ff == bfbi_pkg::ST_READ) &&
                     (op_ff == bfbi_pkg::BFBI_OP_IDENT_HV);
      end
   end

   // Results and handshake to the user side
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         rdata_ff <= '0;
         status_ff <= 8'h00;
         ready_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         if ((state_ff == bfbi_pkg::ST_READ) && sample) begin
            rdata_ff <= rd_word;
         end
         if ((state_ff == bfbi_pkg::ST_POLL) && sample) begin
            status_ff <= dq_sync[7:0];
         end else if (state_ff == bfbi_pkg::ST_CMD1) begin
            status_ff <= {1'b0, status_ff[6:0]} & {~seq_ready, 7'h7f};
         end
         ready_ff <= (nxt_state == bfbi_pkg::ST_IDLE);
         done_ff <= (state_ff == bfbi_pkg::ST_DONE);
      end
   end

   // Boot-block unlock held for the whole program or erase
   logic wp_ff;
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         wp_ff <= 1'b0;
      end else begin
         wp_ff <= busy && is_pe && unlock_ff;
      end
   end

   assign O_READY = ready_ff;
   assign O_DONE = done_ff;
   assign O_RDATA = rdata_ff;
   assign O_STATUS = status_ff;
   assign O_CE_N = ce_n_ff;
   assign O_OE_N = oe_n_ff;
   assign O_WE_N = we_n_ff;
   assign O_RP_N = rp_n_ff;
   assign O_WP = wp_ff;
   assign O_BYTE_N = word_ff;
   assign O_A = a_ff;
   assign O_DQ = dq_ff;
   assign O_DQ_OE = dq_oe_ff;
   assign O_VPP_HI = vpp_ff;
   assign O_ID_HV = id_hv_ff;
endmodule

// [bench/bfbi_flash_model.sv]
// Purpose: Behavioural flash device for the host controller bench
// Assumes: Top boot block; erase clears the 8K-word block holding the address
// Notes: Status stays busy for BUSY_READS status reads after each operation
`timescale 1ns/1ps
module bfbi_flash_model #(
   parameter int BUSY_READS = 3,
   parameter logic [15:0] MFR = 16'h1a3c, // Arbitrary identity value
   parameter logic [15:0] DEV = 16'h2b5e // Arbitrary identity value
) (
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_rp_n,
   input wire logic i_wp,
   input wire logic i_byte_n,
   input wire logic i_vpp_hi,
   input wire logic i_id_hv,
   input wire logic [17:0] i_a,
   input wire logic [15:0] i_d,
   output logic [15:0] o_q,
   output logic [15:0] o_oe
);
   logic [7:0] mem [int];
   logic [6:0] err = 7'h00;
   logic [15:0] q_r = 16'h0000;
   int mode = 0; // 0 array, 1 status, 2 identify
   int pend = 0;
   int busy = 0;
   // Top data pin is the low address bit in byte mode
   wire [18:0] bidx = i_byte_n ? {i_a, 1'b0} : {i_a, i_d[15]};
   wire boot = (i_a[17:13] == 5'h1f);
   // Drive only in a plain read; byte mode leaves the upper pins off
   assign o_oe = (i_ce_n || i_oe_n || !i_we_n || !i_rp_n) ? 16'h0000 :
      i_byte_n ? 16'hffff : 16'h00ff;
   assign o_q = q_r;
   function automatic logic [7:0] rb(input int i);
      return mem.exists(i) ? mem[i] : 8'hff;
   endfunction
   // Read value fixed as the output strobe opens
   always @(negedge i_oe_n) begin
      if (i_id_hv || mode == 2) q_r = i_a[0] ? DEV : MFR;
      else if (mode == 1) q_r = {8'h00, busy == 0, err};
      else q_r = {rb(bidx + 1), rb(bidx)};
      if (mode == 1 && busy > 0) busy--;
   end
   // Commands latch on the rising write strobe, low byte only
   always @(posedge i_we_n) begin
      if (!i_ce_n && i_rp_n) begin
         if (pend != 0) begin
            busy = BUSY_READS;
            mode = 1;
            if (pend == 2 && i_d[7:0] != 8'hd0) err[5:4] = 2'h3;
            else if (!i_vpp_hi) err[3] = 1'b1;
            else if (boot && !i_wp) err[pend+3] = 1'b1;
            else if (pend == 2) begin
               for (int i = 0; i < 16384; i++) mem.delete({i_a[17:13], 14'h0} + i);
            end else begin
               mem[bidx] = rb(bidx) & i_d[7:0];
               if (i_byte_n) mem[bidx+1] = rb(bidx + 1) & i_d[15:8];
            end
            pend = 0;
         end else case (i_d[7:0])
            8'h20: pend = 2;
            8'h10, 8'h40: pend = 1;
            8'hff: mode = 0;
            8'h90: mode = 2;
            8'h50: err = 7'h00;
            default: mode = mode; // Lone confirm is ignored
         endcase
      end
   end
   // Reset pin low drops any sequence and returns to array reads
   always @(negedge i_rp_n) begin
      mode = 0;
      pend = 0;
      busy = 0;
      err = 7'h00;
   end
endmodule

// [bench/bfbi_host_chk.sv]
// Purpose: Pin-level checks of the flash host controller
// Assumes: Bound to bfbi_host; one clock, sync reset
// Notes: Strobe, enable and command-byte relations; read and write data values are left to the bench
`timescale 1ns/1ps
module bfbi_host_chk (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic O_CE_N,
   input wire logic O_OE_N,
   input wire logic O_WE_N,
   input wire logic O_RP_N,
   input wire logic O_BYTE_N,
   input wire logic O_VPP_HI,
   input wire logic [bfbi_pkg::DATA_W-1:0] O_DQ,
   input wire logic [bfbi_pkg::DATA_W-1:0] O_DQ_OE
);
   // One domain, so clock and reset are given once
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);
   // A write strobe opening with a given low-byte command
   sequence s_wr(logic [7:0] c);
      $fell(O_WE_N) && O_DQ[7:0] == c;
   endsequence
   // A data write strobe opening with the program supply raised
   sequence s_data;
      $fell(O_WE_N) && O_VPP_HI;
   endsequence
   a_no_contention: assert property (!(!O_OE_N && !O_WE_N))
      else $error("read and write strobes low together");
   a_byte_upper_off: assert property (!O_BYTE_N |-> O_DQ_OE[14:8] == 7'h00)
      else $error("upper pins driven in byte mode");
   a_byte_addr_pin: assert property (!O_BYTE_N && !O_CE_N |-> O_DQ_OE[15])
      else $error("top pin not driven as address");
   a_cmd_low_byte: assert property (!O_WE_N |-> O_DQ_OE[7:0] == 8'hff)
      else $error("low byte not driven in write");
   a_read_release: assert property (!O_OE_N |-> O_DQ_OE[14:0] == 15'h0000)
      else $error("host drives data during read");
   a_reset_pins: assert property ($rose(I_RESETN) |-> !O_RP_N && O_CE_N && !O_DQ_OE)
      else $error("pins not quiet in reset");
   a_write_width: assert property ($fell(O_WE_N) |-> (!O_WE_N) [*8])
      else $error("write strobe too short");
   a_erase_pair: assert property (s_wr(8'h20) |-> ##[10:20] s_wr(8'hd0))
      else $error("erase setup without confirm");
   a_prog_data: assert property (s_wr(8'h40) |-> ##[10:20] s_data)
      else $error("program setup without data cycle");
   a_vpp_confirm: assert property (s_wr(8'hd0) |-> O_VPP_HI)
      else $error("confirm without program supply");
endmodule

// [bench/tb_top.sv]
// Purpose: Self-checking bench of the flash host controller against the device model
// Assumes: Inputs change on the falling clock edge
// Notes: Table rows first, then a reset in mid-operation
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top;
   typedef struct packed {
      logic [2:0] op;
      logic [18:0] ad;
      logic [15:0] wd;
      logic wm, ul, chk;
      logic [15:0] ex;
   } bfbi_row_s;
   localparam logic [15:0] MFR = 16'h1a3c; // Arbitrary identity value
   localparam logic [15:0] DEV = 16'h2b5e; // Arbitrary identity value
   logic clk = 1'b0, rstn = 1'b0, req = 1'b0, wm = 1'b0, ul = 1'b0;
   logic [2:0] op = 3'h0;
   logic [18:0] ad = 19'h00000;
   logic [15:0] wd = 16'h0000, noise = 16'h5a5a;
   wire ready, done, ce_n, oe_n, we_n, rp_n, wp, byte_n, vpp, idhv;
   wire [15:0] rdata, dq_o, dq_oe, m_q, m_oe, dq;
   wire [7:0] status;
   wire [17:0] a;
   int miscompares = 0, total_checks = 0;
   // Program, byte access, erase, identify, boot lock: inputs then expected value
   bfbi_row_s rows [19] = '{
      '{3'h1, 19'h00005, 16'h1234, 1'b1, 1'b0, 1'b1, 16'h0080},
      '{3'h0, 19'h00005, 16'h0000, 1'b1, 1'b0, 1'b1, 16'h1234},
      '{3'h1, 19'h0000b, 16'h00ab, 1'b0, 1'b0, 1'b1, 16'h0080},
      '{3'h0, 19'h0000b, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h0002},
      '{3'h0, 19'h0000a, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h0034},
      '{3'h0, 19'h00005, 16'h0000, 1'b1, 1'b0, 1'b1, 16'h0234},
      '{3'h2, 19'h00005, 16'h0000, 1'b1, 1'b0, 1'b1, 16'h0080},
      '{3'h0, 19'h00005, 16'h0000, 1'b1, 1'b0, 1'b1, 16'hffff},
      '{3'h3, 19'h00000, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h0000},
      '{3'h0, 19'h00000, 16'h0000, 1'b1, 1'b0, 1'b1, MFR},
      '{3'h0, 19'h00002, 16'h0000, 1'b0, 1'b0, 1'b1, {8'h00, DEV[7:0]}},
      '{3'h5, 19'h00000, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h0000},
      '{3'h4, 19'h00001, 16'h0000, 1'b1, 1'b0, 1'b1, DEV},
      '{3'h4, 19'h00000, 16'h0000, 1'b0, 1'b0, 1'b1, {8'h00, MFR[7:0]}},
      '{3'h0, 19'h00005, 16'h0000, 1'b1, 1'b0, 1'b1, 16'hffff},
      '{3'h1, 19'h3ffff, 16'h5555, 1'b1, 1'b0, 1'b1, 16'h0090},
      '{3'h0, 19'h3ffff, 16'h0000, 1'b1, 1'b0, 1'b1, 16'hffff},
      '{3'h1, 19'h3ffff, 16'h5555, 1'b1, 1'b1, 1'b1, 16'h0090},
      '{3'h0, 19'h3ffff, 16'h0000, 1'b1, 1'b0, 1'b1, 16'h5555}};
   // Clock, and released data lines that toggle rather than hold
   always #5 clk = ~clk;
   always @(posedge clk) noise <= ~noise;
   assign dq = (dq_oe & dq_o) | (~dq_oe & m_oe & m_q) | (~dq_oe & ~m_oe & noise);
   bfbi_host i_bfbi_host (.I_CLK(clk), .I_RESETN(rstn), .I_REQ(req), .I_OP(op), .I_ADDR(ad),
      .I_WDATA(wd), .I_WORD_MODE(wm), .I_BOOT_UNLOCK(ul), .O_READY(ready), .O_DONE(done),
      .O_RDATA(rdata), .O_STATUS(status), .O_CE_N(ce_n), .O_OE_N(oe_n), .O_WE_N(we_n),
      .O_RP_N(rp_n), .O_WP(wp), .O_BYTE_N(byte_n), .O_A(a), .O_DQ(dq_o), .O_DQ_OE(dq_oe),
      .I_DQ(dq), .O_VPP_HI(vpp), .O_ID_HV(idhv));
   bfbi_flash_model i_bfbi_flash_model (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
      .i_rp_n(rp_n), .i_wp(wp), .i_byte_n(byte_n), .i_vpp_hi(vpp), .i_id_hv(idhv), .i_a(a),
      .i_d(dq), .o_q(m_q), .o_oe(m_oe));
   // Prints the verdict and ends the run
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One request; waits are bounded so a hang ends the run
   task automatic run(input bfbi_row_s r, input logic wt);
      int n;
      for (n = 0; n < 300 && ready !== 1'b1; n++) @(negedge clk);
      if (n == 300) begin
         miscompares++;
         $display("ERROR %0t never ready", $time);
         close_out();
      end
      op = r.op;
      ad = r.ad;
      wd = r.wd;
      wm = r.wm;
      ul = r.ul;
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      for (n = 0; wt && n < 3000 && done !== 1'b1; n++) @(negedge clk);
      if (n == 3000) begin
         miscompares++;
         $display("ERROR %0t no completion", $time);
         close_out();
      end
   endtask
   initial begin
      int n;
      logic [15:0] got;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(rp_n, 1'b1)
      for (int i = 0; i < 19; i++) begin
         run(rows[i], 1'b1);
         got = (rows[i].op inside {3'h0, 3'h4}) ? rdata : {8'h00, status};
         if (!rows[i].chk) continue;
         `CHK(got, rows[i].ex)
      end
      // Reset during the first status poll of a program
      run('{3'h1, 19'h00100, 16'h0f0f, 1'b1, 1'b0, 1'b0, 16'h0000}, 1'b0);
      for (n = 0; n < 200 && oe_n !== 1'b0; n++) @(negedge clk);
      if (n == 200) begin
         miscompares++;
         $display("ERROR %0t no status read", $time);
         close_out();
      end
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      `CHK({rp_n, ce_n, vpp, dq_oe}, {1'b0, 1'b1, 1'b0, 16'h0000})
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      run('{3'h0, 19'h00100, 16'h0000, 1'b1, 1'b0, 1'b1, 16'h0f0f}, 1'b1);
      `CHK(rdata, 16'h0f0f)
      close_out();
   end
endmodule
bind bfbi_host bfbi_host_chk i_chk (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .O_CE_N(O_CE_N),
   .O_OE_N(O_OE_N), .O_WE_N(O_WE_N), .O_RP_N(O_RP_N), .O_BYTE_N(O_BYTE_N),
   .O_VPP_HI(O_VPP_HI), .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE));
